// *** common/fbrs_pkg.sv ***
// Constants and types shared by the flash burst read sequencer
package fbrs_pkg;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned ADDR_W     = 20;
    localparam int unsigned REG_AW     = 8;
    localparam int unsigned FIFO_DEPTH = 16;

    // Register offsets, reset value and writable bits
    localparam logic [REG_AW-1:0] CFG_OFF   = 8'h00;
    localparam logic [REG_AW-1:0] STAT_OFF  = 8'h04;
    localparam logic [15:0]       CFG_RESET = 16'h8000;
    localparam logic [15:0]       CFG_WMASK = 16'hbbc7;

    // Field positions of read_config_reg
    localparam int unsigned SYNC_BIT  = 15;
    localparam int unsigned LAT_LSB   = 11;
    localparam int unsigned LAT_W     = 3;
    localparam int unsigned HOLD_BIT  = 9;
    localparam int unsigned WAIT_BIT  = 8;
    localparam int unsigned ORDER_BIT = 7;
    localparam int unsigned EDGE_BIT  = 6;
    localparam int unsigned LEN_LSB   = 0;
    localparam int unsigned LEN_W     = 3;

    // Length codes
    localparam logic [LEN_W-1:0] LEN_4    = 3'h1;
    localparam logic [LEN_W-1:0] LEN_8    = 3'h2;
    localparam logic [LEN_W-1:0] LEN_CONT = 3'h7;

    // Burst address shaping
    localparam logic [ADDR_W-1:0] MASK_4     = 20'h00003;
    localparam logic [ADDR_W-1:0] MASK_8     = 20'h00007;
    localparam logic [ADDR_W-1:0] LAST_IDX_4 = 20'h00003;
    localparam logic [ADDR_W-1:0] LAST_IDX_8 = 20'h00007;
    localparam logic [ADDR_W-1:0] ADDR_LAST  = 20'hfffff;
    localparam logic [3:0]        BOUND_LAST = 4'hf;
    localparam logic [1:0]        GROUP_LAST = 2'h3;
    localparam logic [1:0]        GROUP_FIRST = 2'h0;

    // Bus clocks added to the latency code before the first word
    localparam logic [3:0] LAT_OFFSET = 4'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LAT  = 4'h2,
        ST_DATA = 4'h4,
        ST_GAP  = 4'h8
    } fbrs_state_e;
endpackage : fbrs_pkg

// *** common/fbrs_stream_if.sv ***
// Valid/ready word stream between sequencer and buffer
`timescale 1ns/10ps
interface fbrs_stream_if;
    logic                        valid;
    logic                        ready;
    logic [fbrs_pkg::DATA_W-1:0] data;
    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface : fbrs_stream_if

// *** logic/fbrs_fifo.sv ***
// Word FIFO with valid/ready on both sides and synchronous flush
`timescale 1ns/10ps
module fbrs_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     flush_in,
    fbrs_stream_if.rx                     push_if,
    fbrs_stream_if.tx                     pop_if,
    output logic [$clog2(DEPTH):0]        level_out
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wr_q;
    logic [PW:0]      rd_q;
    logic             full;
    logic             empty;
    logic             do_push;
    logic             do_pop;

    assign full      = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
    assign empty     = (wr_q == rd_q);
    assign do_push   = push_if.valid && !full;
    assign do_pop    = pop_if.ready && !empty;
    assign push_if.ready = !full;
    assign pop_if.valid  = !empty;
    assign pop_if.data   = mem_q[rd_q[PW-1:0]];
    assign level_out     = wr_q - rd_q;

    // Storage
    always_ff @(posedge ref_clk_in) begin
        if (do_push) begin
            mem_q[wr_q[PW-1:0]] <= push_if.data;
        end
    end

    // Pointers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : fbrs_fifo

// *** logic/fbrs_sequencer.sv ***
// Synchronous burst read sequencer of the flash read path
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] Each word held one or two clocks
// [RQ2] Master picks two-clock hold when timing tight
// [RQ3] Wait asserted during delay or one earlier
// [RQ4] Linear or interleaved order; continuous linear only
// [RQ5] Interleaved word is start offset XOR count
// [RQ6] Linear fixed bursts wrap inside aligned group
// [RQ7] Start, data and wait on chosen edge
// [RQ8] Lengths four, eight words or continuous
// [RQ9] Continuous runs linearly to address space end
// [RQ10] Boundary delay absent for four-word-aligned starts
// [RQ11] Start at group end gives full latency delay
// [RQ12] Boundary delay at most once per burst
// [RQ13] Wait flags delay; master holds off sampling
// [RQ14] Length codes 001, 010, 111 only
// [RQ15] Mode bit: 0 burst, 1 page, default page
// [RQ16] Latency code sets clocks to first word
// [RQ17] Fixed encodings of hold, wait, order, edge
// [RQ18] Latch start address, count once per word
// [RQ19] Wait deasserted unless boundary delay pending
module fbrs_sequencer (
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_b_in,
    input  wire logic [fbrs_pkg::REG_AW-1:0]   reg_addr_in,
    input  wire logic [15:0]                   reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [15:0]                   reg_rdata_out,
    input  wire logic                          bus_clk_in,
    input  wire logic                          chip_en_n_in,
    input  wire logic                          addr_valid_n_in,
    input  wire logic [fbrs_pkg::ADDR_W-1:0]   addr_in,
    output logic      [fbrs_pkg::ADDR_W-1:0]   array_addr_out,
    output logic                               array_rd_out,
    input  wire logic [fbrs_pkg::DATA_W-1:0]   array_data_in,
    output logic      [fbrs_pkg::DATA_W-1:0]   dq_out,
    output logic                               dq_oe_n_out,
    output logic                               stall_n_out
);
    localparam int unsigned AW = fbrs_pkg::ADDR_W;
    localparam int unsigned DW = fbrs_pkg::DATA_W;
    localparam int unsigned LW = $clog2(fbrs_pkg::FIFO_DEPTH) + 1;

    fbrs_pkg::fbrs_state_e state_q;
    fbrs_pkg::fbrs_state_e state_d;
    logic [15:0]              cfg_q;
    logic [15:0]              bcfg_q;
    logic [15:0]              rdata_q;
    logic                     bus_clk_q;
    logic                     tick;
    logic                     sync_mode;
    logic                     start;
    logic                     abort;
    logic [AW-1:0]            start_q;
    logic [AW-1:0]            fetch_cnt_q;
    logic [AW-1:0]            out_cnt_q;
    logic [AW-1:0]            out_cnt_d;
    logic [AW-1:0]            fetch_addr;
    logic [AW-1:0]            cur_addr;
    logic [AW-1:0]            nxt_addr;
    logic [AW-1:0]            last_idx;
    logic                     fetch_active_q;
    logic                     fetch_rd_q;
    logic                     rd_pend_q;
    logic                     page_rd_q;
    logic                     issue;
    logic                     fetch_last;
    logic [AW-1:0]            array_addr_q;
    logic                     array_rd_q;
    logic [DW-1:0]            dq_q;
    logic                     dq_oe_n_q;
    logic                     stall_n_q;
    logic                     stall_n_d;
    logic [3:0]               tick_cnt_q;
    logic [3:0]               tick_cnt_d;
    logic                     hold_cnt_q;
    logic                     hold_cnt_d;
    logic                     gap_done_q;
    logic                     gap_done_d;
    logic                     pop_now;
    logic                     burst_end;
    logic                     gap_due;
    logic                     gap_due_d;
    logic [3:0]               gap_len;
    logic [3:0]               lat_ext;
    logic [3:0]               group_gap;
    logic [LW-1:0]            level;
    logic [fbrs_pkg::LEN_W-1:0] b_len;
    logic [fbrs_pkg::LAT_W-1:0] b_lat;
    logic                     b_lin;
    logic                     b_hold;
    logic                     b_wait_early;
    logic                     b_cont;

    fbrs_stream_if push_if ();
    fbrs_stream_if pop_if ();

    // Burst word address for a given count
    function automatic logic [AW-1:0] seq_addr(input logic [AW-1:0] base,
                                               input logic [AW-1:0] cnt,
                                               input logic [fbrs_pkg::LEN_W-1:0] len,
                                               input logic lin);
        logic [AW-1:0] msk;
        msk = (len == fbrs_pkg::LEN_8) ? fbrs_pkg::MASK_8 : fbrs_pkg::MASK_4;
        if (len == fbrs_pkg::LEN_CONT) begin
            seq_addr = base + cnt;
        end else if (lin) begin
            seq_addr = (base & ~msk) | ((base + cnt) & msk);
        end else begin
            seq_addr = (base & ~msk) | ((base ^ cnt) & msk);
        end
    endfunction : seq_addr

    // Configuration fields of the running burst
    // [RQ17] fixed bit meanings
    assign b_len        = bcfg_q[fbrs_pkg::LEN_LSB +: fbrs_pkg::LEN_W];
    assign b_lat        = bcfg_q[fbrs_pkg::LAT_LSB +: fbrs_pkg::LAT_W];
    assign b_lin        = bcfg_q[fbrs_pkg::ORDER_BIT];
    assign b_hold       = bcfg_q[fbrs_pkg::HOLD_BIT];
    assign b_wait_early = bcfg_q[fbrs_pkg::WAIT_BIT];
    // [RQ8] length decode
    assign b_cont   = (b_len == fbrs_pkg::LEN_CONT);
    // [RQ14] reserved codes run as four words
    assign last_idx = (b_len == fbrs_pkg::LEN_8) ? fbrs_pkg::LAST_IDX_8 : fbrs_pkg::LAST_IDX_4;

    // Register file
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_q <= fbrs_pkg::CFG_RESET;
        end else if (reg_wr_in && reg_addr_in == fbrs_pkg::CFG_OFF) begin
            cfg_q <= reg_wdata_in & fbrs_pkg::CFG_WMASK;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                fbrs_pkg::CFG_OFF:  rdata_q <= cfg_q;
                fbrs_pkg::STAT_OFF: rdata_q <= {5'h00, fetch_active_q, level, gap_done_q,
                                                state_q};
                default:            rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // Bus clock edge detect
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_clk_q <= 1'b0;
        end else begin
            bus_clk_q <= bus_clk_in;
        end
    end

    // [RQ7] active edge chosen by edge bit
    assign tick = cfg_q[fbrs_pkg::EDGE_BIT] ? (bus_clk_in & ~bus_clk_q)
                                            : (~bus_clk_in & bus_clk_q);
    // [RQ15] burst only with mode bit clear
    assign sync_mode = ~cfg_q[fbrs_pkg::SYNC_BIT];
    assign start     = tick && sync_mode && !chip_en_n_in && !addr_valid_n_in;
    assign abort     = chip_en_n_in || !sync_mode;

    // [RQ18] latch start address and settings
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_q <= '0;
            bcfg_q  <= fbrs_pkg::CFG_RESET;
        end else if (start) begin
            start_q <= addr_in;
            bcfg_q  <= cfg_q;
        end
    end

    // Fetch engine filling the buffer
    // [RQ4] [RQ5] [RQ6] [RQ9] burst address order
    assign fetch_addr = seq_addr(start_q, fetch_cnt_q, b_len, b_lin);
    assign fetch_last = b_cont ? (fetch_addr == fbrs_pkg::ADDR_LAST) : (fetch_cnt_q == last_idx);
    assign issue      = fetch_active_q && !fetch_rd_q && !rd_pend_q && push_if.ready;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fetch_active_q <= 1'b0;
            fetch_cnt_q    <= '0;
            fetch_rd_q     <= 1'b0;
            rd_pend_q      <= 1'b0;
        end else if (start || abort) begin
            fetch_active_q <= start;
            fetch_cnt_q    <= '0;
            fetch_rd_q     <= 1'b0;
            rd_pend_q      <= 1'b0;
        end else begin
            fetch_rd_q <= issue;
            rd_pend_q  <= fetch_rd_q;
            if (issue) begin
                fetch_cnt_q <= fetch_cnt_q + 1'b1;
                if (fetch_last) begin
                    fetch_active_q <= 1'b0;
                end
            end
        end
    end

    // Array port, shared with page reads
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            array_addr_q <= '0;
            array_rd_q   <= 1'b0;
            page_rd_q    <= 1'b0;
        end else begin
            if (issue) begin
                array_addr_q <= fetch_addr;
            end else if (!sync_mode && !chip_en_n_in) begin
                array_addr_q <= addr_in;
            end
            array_rd_q <= issue || (!sync_mode && !chip_en_n_in);
            page_rd_q  <= !sync_mode && !chip_en_n_in;
        end
    end

    assign push_if.valid = rd_pend_q;
    assign push_if.data  = array_data_in;
    assign pop_if.ready  = pop_now;

    fbrs_fifo #(
        .WIDTH (fbrs_pkg::DATA_W),
        .DEPTH (fbrs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .flush_in   (start || abort),
        .push_if    (push_if),
        .pop_if     (pop_if),
        .level_out  (level)
    );

    // Boundary delay length from start offset
    assign lat_ext   = {1'b0, b_lat};
    assign group_gap = 4'(fbrs_pkg::GROUP_LAST - start_q[1:0]);
    always_comb begin
        // [RQ10] aligned start, no delay
        if (start_q[1:0] == fbrs_pkg::GROUP_FIRST) begin
            gap_len = '0;
        // [RQ11] worst case equals latency code
        end else if (lat_ext > group_gap) begin
            gap_len = lat_ext - group_gap;
        end else begin
            gap_len = '0;
        end
    end

    assign cur_addr  = seq_addr(start_q, out_cnt_q, b_len, b_lin);
    assign nxt_addr  = seq_addr(start_q, out_cnt_d, b_len, b_lin);
    // [RQ9] continuous stops at last address
    assign burst_end = b_cont ? (cur_addr == fbrs_pkg::ADDR_LAST) : (out_cnt_q == last_idx);
    // [RQ12] once, only on boundary crossing
    assign gap_due   = b_cont && !gap_done_q && (gap_len != '0)
                       && (cur_addr[3:0] == fbrs_pkg::BOUND_LAST);
    assign gap_due_d = b_cont && !gap_done_d && (gap_len != '0)
                       && (nxt_addr[3:0] == fbrs_pkg::BOUND_LAST);

    // Output sequencing on bus clock edges
    always_comb begin
        state_d    = state_q;
        tick_cnt_d = tick_cnt_q;
        hold_cnt_d = hold_cnt_q;
        out_cnt_d  = out_cnt_q;
        gap_done_d = gap_done_q;
        pop_now    = 1'b0;
        if (start) begin
            // [RQ16] latency from strobe to first word
            state_d    = fbrs_pkg::ST_LAT;
            tick_cnt_d = {1'b0, cfg_q[fbrs_pkg::LAT_LSB +: fbrs_pkg::LAT_W]}
                         + fbrs_pkg::LAT_OFFSET - 4'h1;
            hold_cnt_d = 1'b0;
            out_cnt_d  = '0;
            gap_done_d = 1'b0;
        end else if (abort) begin
            state_d = fbrs_pkg::ST_IDLE;
        end else if (tick) begin
            case (state_q)
                fbrs_pkg::ST_IDLE: begin
                    state_d = fbrs_pkg::ST_IDLE;
                end
                fbrs_pkg::ST_LAT: begin
                    if (tick_cnt_q != '0) begin
                        tick_cnt_d = tick_cnt_q - 4'h1;
                    end else if (pop_if.valid) begin
                        pop_now = 1'b1;
                        state_d = fbrs_pkg::ST_DATA;
                    end
                end
                fbrs_pkg::ST_DATA: begin
                    // [RQ1] hold one or two clocks
                    if (hold_cnt_q != b_hold) begin
                        hold_cnt_d = 1'b1;
                    end else if (burst_end) begin
                        state_d = fbrs_pkg::ST_IDLE;
                    end else if (gap_due) begin
                        state_d    = fbrs_pkg::ST_GAP;
                        tick_cnt_d = gap_len - 4'h1;
                        gap_done_d = 1'b1;
                    end else if (pop_if.valid) begin
                        // [RQ18] count once per word
                        pop_now    = 1'b1;
                        hold_cnt_d = 1'b0;
                        out_cnt_d  = out_cnt_q + 1'b1;
                    end
                end
                fbrs_pkg::ST_GAP: begin
                    // [RQ13] no new word during delay
                    if (tick_cnt_q != '0) begin
                        tick_cnt_d = tick_cnt_q - 4'h1;
                    end else if (pop_if.valid) begin
                        pop_now    = 1'b1;
                        hold_cnt_d = 1'b0;
                        out_cnt_d  = out_cnt_q + 1'b1;
                        state_d    = fbrs_pkg::ST_DATA;
                    end
                end
                default: begin
                    state_d = fbrs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // [RQ3] [RQ19] wait during delay or one word early
    assign stall_n_d = !((state_d == fbrs_pkg::ST_GAP)
                         || (b_wait_early && state_d == fbrs_pkg::ST_DATA && gap_due_d));

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q    <= fbrs_pkg::ST_IDLE;
            tick_cnt_q <= '0;
            hold_cnt_q <= 1'b0;
            out_cnt_q  <= '0;
            gap_done_q <= 1'b0;
            stall_n_q  <= 1'b1;
        end else begin
            state_q    <= state_d;
            tick_cnt_q <= tick_cnt_d;
            hold_cnt_q <= hold_cnt_d;
            out_cnt_q  <= out_cnt_d;
            gap_done_q <= gap_done_d;
            stall_n_q  <= stall_n_d;
        end
    end

    // Data pins
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dq_q      <= '0;
            dq_oe_n_q <= 1'b1;
        end else begin
            if (pop_now) begin
                dq_q <= pop_if.data;
            end else if (page_rd_q) begin
                dq_q <= array_data_in;
            end
            dq_oe_n_q <= !(state_d == fbrs_pkg::ST_DATA || state_d == fbrs_pkg::ST_GAP
                           || (page_rd_q && !chip_en_n_in && !sync_mode));
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign array_addr_out = array_addr_q;
    assign array_rd_out   = array_rd_q;
    assign dq_out         = dq_q;
    assign dq_oe_n_out    = dq_oe_n_q;
    assign stall_n_out    = stall_n_q;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_hold_two_clk: assert property ( // [RQ1]
        (state_q == fbrs_pkg::ST_DATA && pop_now && !start) |-> hold_cnt_q == b_hold)
        else $error("word released before its hold time");
    a_wait_in_gap: assert property ( // [RQ3]
        (state_q == fbrs_pkg::ST_GAP) |-> !stall_n_out)
        else $error("wait not asserted during boundary delay");
    a_wait_idle_high: assert property ( // [RQ19]
        (state_q == fbrs_pkg::ST_IDLE || state_q == fbrs_pkg::ST_LAT) |-> stall_n_out)
        else $error("wait asserted outside a boundary delay");
    a_interleave_pair: assert property ( // [RQ5]
        (issue && fetch_cnt_q == 20'h00001 && !b_lin && !b_cont)
        |=> (array_addr_q[0] != start_q[0]) && (array_addr_q[AW-1:1] == start_q[AW-1:1]))
        else $error("interleaved second word not start offset xor one");
    a_linear_wrap: assert property ( // [RQ6]
        (issue && b_lin && b_len == fbrs_pkg::LEN_4)
        |=> array_addr_q[AW-1:2] == start_q[AW-1:2])
        else $error("linear four-word burst left its aligned group");
    a_cont_linear: assert property ( // [RQ9]
        (issue && b_cont) |=> array_addr_q == start_q + $past(fetch_cnt_q))
        else $error("continuous burst address not linear");
    a_gap_once: assert property ( // [RQ12]
        (state_q == fbrs_pkg::ST_GAP && $past(state_q) == fbrs_pkg::ST_DATA)
        |-> !$past(gap_done_q))
        else $error("boundary delay entered twice");
    a_aligned_no_gap: assert property ( // [RQ10]
        (start_q[1:0] == fbrs_pkg::GROUP_FIRST && !$past(start)) |-> state_q != fbrs_pkg::ST_GAP)
        else $error("boundary delay on an aligned start");
    a_worst_gap: assert property ( // [RQ11]
        (state_q == fbrs_pkg::ST_DATA && state_d == fbrs_pkg::ST_GAP
         && start_q[1:0] == fbrs_pkg::GROUP_LAST) |=> tick_cnt_q == lat_ext - 4'h1)
        else $error("worst case delay differs from latency code");
    a_page_no_burst: assert property ( // [RQ15]
        cfg_q[fbrs_pkg::SYNC_BIT] |=> state_q == fbrs_pkg::ST_IDLE)
        else $error("burst running in page mode");
    a_fixed_length: assert property ( // [RQ8]
        (state_q == fbrs_pkg::ST_DATA && !b_cont) |-> out_cnt_q <= last_idx)
        else $error("fixed burst ran past its length");

    c_burst_four: cover property (state_q == fbrs_pkg::ST_DATA && b_len == fbrs_pkg::LEN_4
                                  && out_cnt_q == last_idx);
    c_interleave_eight: cover property (state_q == fbrs_pkg::ST_DATA && !b_lin
                                        && b_len == fbrs_pkg::LEN_8);
    c_cont_gap: cover property (state_q == fbrs_pkg::ST_GAP);
    c_early_wait: cover property (!stall_n_out && state_q == fbrs_pkg::ST_DATA);
endmodule : fbrs_sequencer

// *** sim/fbrs_bus_model.sv ***
// Bus master model: burst clock, enable, strobe, address
`timescale 1ns/10ps
module fbrs_bus_model (
    input  wire logic   ref_clk_in,
    output logic        bclk_out,
    output logic        ce_n_out,
    output logic        adv_n_out,
    output logic [19:0] addr_out
);
    initial begin
        bclk_out = 1'b0;
        ce_n_out = 1'b1;
        adv_n_out = 1'b1;
        addr_out = 20'h0;
    end
    task automatic burst(input logic fall, input logic [19:0] a, input int n);
        bclk_out <= fall;
        repeat (4) @(posedge ref_clk_in);
        ce_n_out <= 1'b0;
        adv_n_out <= 1'b0;
        addr_out <= a;
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge ref_clk_in);
            bclk_out <= ~bclk_out;
            repeat (2) @(posedge ref_clk_in);
            adv_n_out <= 1'b1;
            addr_out <= ~a;
        end
        @(posedge ref_clk_in);
        ce_n_out <= 1'b1;
    endtask : burst
endmodule : fbrs_bus_model

// *** sim/tb.sv ***
// Self-checking bench for the burst read sequencer
`timescale 1ns/10ps
module tb;
    logic ref_clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, array_rd_out;
    logic [7:0] reg_addr_in = 0;
    logic [15:0] reg_wdata_in = 0, reg_rdata_out, array_data_in = 0, dq_out, pdq;
    logic [19:0] array_addr_out, a;
    logic bclk, ce_n, adv_n, dq_oe_n_out, stall_n_out, poe, prd;
    logic [19:0] baddr;
    logic [31:0] r;
    int n_fail, tests_run, n_stall, s0, n_rd;
    logic [15:0] exp_q[$], rq[$];
    always #5 ref_clk_in = ~ref_clk_in;
    fbrs_sequencer fbrs_sequencer_inst (.ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_clk_in(bclk), .chip_en_n_in(ce_n),
        .addr_valid_n_in(adv_n), .addr_in(baddr), .array_addr_out, .array_rd_out,
        .array_data_in, .dq_out, .dq_oe_n_out, .stall_n_out);
    fbrs_bus_model fbrs_bus_model_inst (.ref_clk_in, .bclk_out(bclk), .ce_n_out(ce_n),
        .adv_n_out(adv_n), .addr_out(baddr));
    always @(posedge ref_clk_in) array_data_in <= array_addr_out[15:0] ^ 16'h5a5a;
    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        tests_run++;
        if (got !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, e);
        end
    endtask : chk
    always @(posedge ref_clk_in) begin
        poe <= dq_oe_n_out;
        pdq <= dq_out;
        prd <= reg_rd_in;
        if (stall_n_out === 1'b0) n_stall++;
        if (array_rd_out === 1'b1) n_rd++;
        if (prd === 1'b1) chk(reg_rdata_out, rq.pop_front());
        if (dq_oe_n_out === 1'b0 && (poe || dq_out !== pdq) && exp_q.size() > 0)
            chk(dq_out, exp_q.pop_front());
    end
    task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] ad, input logic [15:0] e);
        rq.push_back(e);
        @(posedge ref_clk_in);
        reg_addr_in <= ad;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
    endtask : rd_reg
    task automatic go(input logic [2:0] lat, input logic hold, wc, ord, fall,
                      input logic [2:0] len, input logic [19:0] st, input int k);
        logic [19:0] m;
        m = (len == fbrs_pkg::LEN_8) ? 20'h7 : 20'h3;
        wr_reg(8'h00, {2'b00, lat, 1'b0, hold, wc, ord, ~fall, 3'b000, len});
        for (int i = 0; i < k; i++) begin
            if (len == fbrs_pkg::LEN_CONT) a = st + 20'(i);
            else if (ord) a = (st & ~m) | ((st + 20'(i)) & m);
            else a = (st & ~m) | ((st & m) ^ 20'(i));
            exp_q.push_back(a[15:0] ^ 16'h5a5a);
        end
        n_stall = 0;
        n_rd = 0;
        fbrs_bus_model_inst.burst(fall, st, 2 * int'(lat) + 4 + k * (int'(hold) + 1));
        chk(16'(exp_q.size()), 16'h0);
        if (len != fbrs_pkg::LEN_CONT) chk(16'(n_rd), 16'(k));
        repeat (4) @(posedge ref_clk_in);
    endtask : go
    task automatic report_and_stop;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        n_fail++;
        report_and_stop;
    end
    initial begin
        void'($urandom(74809));
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd_reg(8'h00, fbrs_pkg::CFG_RESET);
        wr_reg(8'h00, 16'hffff);
        rd_reg(8'h00, fbrs_pkg::CFG_WMASK);
        rd_reg(8'h08, 16'h0);
        go(3'd2, 1'b0, 1'b0, 1'b1, 1'b0, fbrs_pkg::LEN_4, 20'h2, 4);
        go(3'd3, 1'b0, 1'b0, 1'b1, 1'b1, fbrs_pkg::LEN_8, 20'h3, 8);
        go(3'd2, 1'b1, 1'b0, 1'b0, 1'b0, fbrs_pkg::LEN_8, 20'h15, 8);
        go(3'd4, 1'b0, 1'b0, 1'b0, 1'b0, fbrs_pkg::LEN_4, 20'h1, 4);
        go(3'd3, 1'b0, 1'b0, 1'b1, 1'b0, fbrs_pkg::LEN_CONT, 20'h3, 20);
        s0 = n_stall;
        chk(16'(s0 > 0), 16'h1);
        go(3'd3, 1'b0, 1'b1, 1'b1, 1'b0, fbrs_pkg::LEN_CONT, 20'h3, 20);
        chk(16'(n_stall > s0), 16'h1);
        go(3'd3, 1'b0, 1'b1, 1'b1, 1'b0, fbrs_pkg::LEN_CONT, 20'h4, 20);
        chk(16'(n_stall), 16'h0);
        go(3'd2, 1'b0, 1'b0, 1'b1, 1'b0, fbrs_pkg::LEN_CONT, 20'hffffc, 4);
        for (int j = 0; j < 4; j++) begin
            r = $urandom;
            go(3'(2 + r % 5), r[0], 1'b0, r[1], r[2], r[3] ? fbrs_pkg::LEN_8 : fbrs_pkg::LEN_4,
               r[31:12], r[3] ? 8 : 4);
        end
        report_and_stop;
    end
endmodule : tb
